// ==== ssel_pkg.sv ====
/*
  Shared constants and types for the speed reference source selector:
  register byte offsets, reset values, mode and terminal-function encodings,
  source codes and timing figures.
  Assumes a 25 MHz control clock and a 32-bit AHB-Lite register bus.
*/
package ssel_pkg;

  // Reference value width
  localparam int REF_WIDTH = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_PSEL = 8'h04;
  localparam logic [7:0] OFF_AUTODIS = 8'h08;
  localparam logic [7:0] OFF_SCAN = 8'h0c;
  localparam logic [7:0] OFF_KEYPAD = 8'h10;
  localparam logic [7:0] OFF_DEST = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_PRESET0 = 8'h20;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] PSEL_RST = 4'h0;
  localparam logic AUTODIS_RST = 1'b1;
  localparam logic [15:0] SCAN_RST = 16'h000a;
  localparam logic [15:0] KEYPAD_RST = 16'h0000;
  localparam logic [15:0] PRESET_RST = 16'h0000;

  // Preset selector values
  localparam logic [3:0] PSEL_MAX = 4'h9;
  localparam logic [3:0] PSEL_SCAN = 4'h9;
  localparam int NUM_PRESETS = 8;

  // Active source codes: presets 1..8 map to 2..9
  localparam logic [3:0] SRC_ANALOG1 = 4'h0;
  localparam logic [3:0] SRC_ANALOG2 = 4'h1;
  localparam logic [3:0] SRC_PRESET_BASE = 4'h1;
  localparam logic [3:0] SRC_KEYPAD = 4'ha;
  localparam logic [3:0] SRC_PRECISION = 4'hb;

  // Scan time base: interval register counts these ticks
  localparam longint CLK_HZ = 25000000;
  localparam longint SCAN_TICK_US = 1000;
  localparam int SCAN_TICK_CYCLES_DEF = int'((CLK_HZ * SCAN_TICK_US) / 1000000);

  // Reference mode encoding
  typedef enum logic [2:0] {
    MODE_ANALOG_ONE_OR_TWO = 3'b000,
    MODE_ANALOG_ONE_OR_PRESET = 3'b001,
    MODE_ANALOG_TWO_OR_PRESET = 3'b010,
    MODE_PRESET_ONLY = 3'b011,
    MODE_KEYPAD = 3'b100,
    MODE_PRECISION = 3'b101
  } ssel_mode_e;

  // Function routed to a select terminal
  typedef enum logic [1:0] {
    DEST_NONE = 2'b00,
    DEST_ANALOG_SEL = 2'b01,
    DEST_PRESET_BIT0 = 2'b10,
    DEST_PRESET_BIT1 = 2'b11
  } ssel_dest_e;

  // Destinations of both select terminals, as held in the dest register
  typedef struct packed {
    ssel_dest_e dest_b;
    ssel_dest_e dest_a;
  } ssel_dest_s;

endpackage

// ==== ssel_ref_selector.sv ====
/*
  Speed reference source selector: AHB-Lite register file, select terminal
  routing with auto-configuration, preset scan timer, source decode and
  keypad sequencing override.
  Assumes analog, precision and sequencing inputs come from logic on clk_in;
  terminal and keypad key inputs are asynchronous pins.
*/
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/100ps
module ssel_ref_selector
  import ssel_pkg::*;
#(
  parameter int REF_W = REF_WIDTH,
  parameter int SCAN_TICK_CYCLES = SCAN_TICK_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic drive_reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic select_terminal_a_in,
  input wire logic select_terminal_b_in,
  input wire logic keypad_run_key_in,
  input wire logic keypad_stop_key_in,
  input wire logic [REF_W-1:0] analog_one_in,
  input wire logic [REF_W-1:0] analog_two_in,
  input wire logic [REF_W-1:0] precision_ref_in,
  input wire logic [4:0] seq_bits_in,
  input wire logic seq_enable_in,
  input wire logic jog_request_in,
  output logic [REF_W-1:0] active_ref_out,
  output logic [3:0] active_source_out,
  output logic [4:0] seq_bits_out,
  output logic seq_enable_out,
  output logic run_command_out,
  output logic jog_enable_out,
  output logic keypad_mode_out
);

  localparam int PIN_N = 4; // Terminals a, b, run key, stop key
  localparam int TICK_W = $clog2(SCAN_TICK_CYCLES + 1);

  // Software-visible registers
  logic [2:0] mode_reg; // Reference mode field
  logic [3:0] psel_reg; // Preset selector
  logic autodis_reg; // Terminal auto-configuration disable
  logic [15:0] scan_reg; // Scan interval in ticks
  logic [REF_W-1:0] keypad_ref_reg; // Keypad reference
  ssel_dest_s dest_reg; // Terminal destinations
  logic [REF_W-1:0] preset_reg [NUM_PRESETS]; // Preset values 1..8

  // Bus pipeline state
  logic wr_pend_reg; // Write data phase pending
  logic [7:0] wr_addr_reg; // Latched write offset

  // Pin synchronisers and filtered levels
  logic [PIN_N-1:0] sync1_reg;
  logic [PIN_N-1:0] sync2_reg;
  logic [PIN_N-1:0] sync3_reg;
  logic [PIN_N-1:0] pin_reg;

  // Scan timer state
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [15:0] dwell_cnt_reg;
  logic [3:0] scan_num_reg; // Scan position, source number 1..8

  // Keypad run latch
  logic kp_run_reg;

  // Decode results
  logic [3:0] eff_sel;
  logic sel_bit0;
  logic sel_bit1;
  logic sel_an2;
  logic [3:0] term_num;
  logic [3:0] src_next;
  logic [REF_W-1:0] ref_next;
  logic addr_ok;
  logic wr_now;
  logic [31:0] rd_next;
  logic [31:0] status_word;
  logic keypad_sel;
  ssel_dest_s auto_dest;

  // Address phase accepted by this slave
  assign addr_ok = hsel_in && hready_in && htrans_in[1];
  assign wr_now = wr_pend_reg;
  assign keypad_sel = (mode_reg == MODE_KEYPAD);

  // Pin synchronisers: three stages per pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= gi == 0 ? select_terminal_a_in :
                           gi == 1 ? select_terminal_b_in :
                           gi == 2 ? keypad_run_key_in : keypad_stop_key_in;
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          // Change counts only once second and third stage agree
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            pin_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // Bus data phase tracking; writes land in the cycle after the address
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite_in;
      wr_addr_reg <= haddr_in[7:0];
    end
  end

  // Always zero-wait, always OKAY
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // Mode register; codes above precision are refused
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg <= MODE_RST;
    end else if (wr_now && wr_addr_reg == OFF_MODE && hwdata_in[2:0] <= MODE_PRECISION) begin
      mode_reg <= hwdata_in[2:0];
    end
  end

  // Preset selector; values above nine are refused
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      psel_reg <= PSEL_RST;
    end else if (wr_now && wr_addr_reg == OFF_PSEL && hwdata_in[31:4] == 28'h0000000
                 && hwdata_in[3:0] <= PSEL_MAX) begin
      psel_reg <= hwdata_in[3:0];
    end
  end

  // Scalar configuration registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      autodis_reg <= AUTODIS_RST;
      scan_reg <= SCAN_RST;
      keypad_ref_reg <= KEYPAD_RST;
    end else if (wr_now) begin
      if (wr_addr_reg == OFF_AUTODIS) begin
        autodis_reg <= hwdata_in[0];
      end
      if (wr_addr_reg == OFF_SCAN) begin
        scan_reg <= hwdata_in[15:0];
      end
      if (wr_addr_reg == OFF_KEYPAD) begin
        keypad_ref_reg <= hwdata_in[REF_W-1:0];
      end
    end
  end

  // Preset storage, one word each
  generate
    for (gi = 0; gi < NUM_PRESETS; gi++) begin : g_preset
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          preset_reg[gi] <= PRESET_RST;
        end else if (wr_now && wr_addr_reg == OFF_PRESET0 + 8'(4 * gi)) begin
          preset_reg[gi] <= hwdata_in[REF_W-1:0];
        end
      end
    end
  endgenerate

  // Destinations implied by the mode field
  always_comb begin
    auto_dest.dest_a = DEST_NONE;
    auto_dest.dest_b = DEST_NONE;
    case (mode_reg)
      MODE_ANALOG_ONE_OR_TWO: begin
        auto_dest.dest_a = DEST_ANALOG_SEL;
      end
      MODE_ANALOG_ONE_OR_PRESET, MODE_ANALOG_TWO_OR_PRESET, MODE_PRESET_ONLY: begin
        auto_dest.dest_a = DEST_PRESET_BIT0;
        auto_dest.dest_b = DEST_PRESET_BIT1;
      end
      default: begin
        auto_dest.dest_a = DEST_NONE;
      end
    endcase
  end

  // Terminal destinations: auto-loaded at a drive reset while auto set-up is on, user owned while it is off
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dest_reg <= ssel_dest_s'({DEST_NONE, DEST_ANALOG_SEL}); // Mode zero layout
    end else if (!autodis_reg) begin
      // Held until drive reset so a running drive never changes routing
      if (drive_reset_in) begin
        dest_reg <= auto_dest;
      end
    end else if (wr_now && wr_addr_reg == OFF_DEST) begin
      dest_reg <= ssel_dest_s'(hwdata_in[3:0]);
    end
  end

  // Scan tick prescaler, free running only while scanning
  always_ff @(posedge clk_in) begin
    if (rst_in || psel_reg != PSEL_SCAN) begin
      tick_cnt_reg <= '0;
    end else if (tick_cnt_reg == TICK_W'(SCAN_TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // Dwell counter and scan position
  always_ff @(posedge clk_in) begin
    if (rst_in || psel_reg != PSEL_SCAN) begin
      dwell_cnt_reg <= 16'h0000;
      scan_num_reg <= 4'h1;
    end else if (tick_cnt_reg == TICK_W'(SCAN_TICK_CYCLES - 1)) begin
      // Interval zero behaves as one tick
      if (dwell_cnt_reg + 16'h0001 >= scan_reg) begin
        dwell_cnt_reg <= 16'h0000;
        scan_num_reg <= (scan_num_reg == 4'(NUM_PRESETS)) ? 4'h1 : scan_num_reg + 4'h1;
      end else begin
        dwell_cnt_reg <= dwell_cnt_reg + 16'h0001;
      end
    end
  end

  // Terminal functions as routed
  always_comb begin
    sel_bit0 = (dest_reg.dest_a == DEST_PRESET_BIT0 && pin_reg[0]) ||
               (dest_reg.dest_b == DEST_PRESET_BIT0 && pin_reg[1]);
    sel_bit1 = (dest_reg.dest_a == DEST_PRESET_BIT1 && pin_reg[0]) ||
               (dest_reg.dest_b == DEST_PRESET_BIT1 && pin_reg[1]);
    sel_an2 = (dest_reg.dest_a == DEST_ANALOG_SEL && pin_reg[0]) ||
              (dest_reg.dest_b == DEST_ANALOG_SEL && pin_reg[1]);
    term_num = {2'b00, sel_bit1, sel_bit0} + 4'h1;
    eff_sel = (psel_reg == PSEL_SCAN) ? scan_num_reg : psel_reg;
  end

  // Source decode
  always_comb begin
    src_next = SRC_ANALOG1;
    case (mode_reg)
      MODE_ANALOG_ONE_OR_TWO: begin
        if (eff_sel <= 4'h1) begin
          src_next = sel_an2 ? SRC_ANALOG2 : SRC_ANALOG1;
        end else begin
          src_next = SRC_PRESET_BASE + eff_sel;
        end
      end
      MODE_ANALOG_ONE_OR_PRESET, MODE_ANALOG_TWO_OR_PRESET: begin
        if (eff_sel == 4'h0 && term_num != 4'h1) begin
          src_next = SRC_PRESET_BASE + term_num;
        end else if (eff_sel <= 4'h1) begin
          src_next = (mode_reg == MODE_ANALOG_TWO_OR_PRESET) ? SRC_ANALOG2 : SRC_ANALOG1;
        end else begin
          src_next = SRC_PRESET_BASE + eff_sel;
        end
      end
      MODE_PRESET_ONLY: begin
        if (eff_sel == 4'h0) begin
          src_next = SRC_PRESET_BASE + term_num;
        end else begin
          src_next = SRC_PRESET_BASE + eff_sel;
        end
      end
      MODE_KEYPAD: begin
        src_next = SRC_KEYPAD;
      end
      MODE_PRECISION: begin
        src_next = SRC_PRECISION;
      end
      default: begin
        src_next = SRC_ANALOG1;
      end
    endcase
  end

  // Value behind the chosen source
  always_comb begin
    case (src_next)
      SRC_ANALOG1: ref_next = analog_one_in;
      SRC_ANALOG2: ref_next = analog_two_in;
      SRC_KEYPAD: ref_next = keypad_ref_reg;
      SRC_PRECISION: ref_next = precision_ref_in;
      default: ref_next = preset_reg[3'(src_next - SRC_PRESET_BASE - 4'h1)];
    endcase
  end

  // Registered reference outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_ref_out <= '0;
      active_source_out <= SRC_ANALOG1;
    end else begin
      active_ref_out <= ref_next;
      active_source_out <= src_next;
    end
  end

  // Keypad run latch; stop key wins when both are held
  always_ff @(posedge clk_in) begin
    if (rst_in || !keypad_sel) begin
      kp_run_reg <= 1'b0;
    end else if (pin_reg[3]) begin
      kp_run_reg <= 1'b0;
    end else if (pin_reg[2]) begin
      kp_run_reg <= 1'b1;
    end
  end

  // Sequencer outputs; keypad mode masks terminal sequencing and jog
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq_bits_out <= 5'h00;
      seq_enable_out <= 1'b0;
      run_command_out <= 1'b0;
      jog_enable_out <= 1'b0;
      keypad_mode_out <= 1'b0;
    end else if (keypad_sel) begin
      seq_bits_out <= 5'h00;
      seq_enable_out <= 1'b0;
      run_command_out <= kp_run_reg;
      jog_enable_out <= 1'b0;
      keypad_mode_out <= 1'b1;
    end else begin
      seq_bits_out <= seq_bits_in;
      seq_enable_out <= seq_enable_in;
      run_command_out <= seq_enable_in && seq_bits_in[0];
      jog_enable_out <= jog_request_in;
      keypad_mode_out <= 1'b0;
    end
  end

  // Status word for software
  assign status_word = {18'h00000, pin_reg[1], pin_reg[0], dest_reg,
                        kp_run_reg, scan_num_reg[2:0], active_source_out};

  // Read mux, sampled in the address phase
  always_comb begin
    rd_next = 32'h00000000;
    case (haddr_in[7:0])
      OFF_MODE: rd_next = {29'h00000000, mode_reg};
      OFF_PSEL: rd_next = {28'h0000000, psel_reg};
      OFF_AUTODIS: rd_next = {31'h00000000, autodis_reg};
      OFF_SCAN: rd_next = {16'h0000, scan_reg};
      OFF_KEYPAD: rd_next = 32'(keypad_ref_reg);
      OFF_DEST: rd_next = {28'h0000000, dest_reg};
      OFF_STATUS: rd_next = status_word;
      default: begin
        // Preset window; anything else reads zero
        if (haddr_in[7:5] == OFF_PRESET0[7:5] && haddr_in[1:0] == 2'b00) begin
          rd_next = 32'(preset_reg[haddr_in[4:2]]);
        end
      end
    endcase
  end

  // Read data register, valid in the data phase
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (addr_ok && !hwrite_in) begin
      hrdata_out <= rd_next;
    end
  end

endmodule

// ==== ssel_ref_selector_properties.sv ====
/*
  Checker for the reference selector: keypad overrides, pass-through
  paths, source code range and bus response.
  Assumes binding to every ssel_ref_selector instance; sees its ports only.
*/
`timescale 1ns/100ps
module ssel_checker
  import ssel_pkg::*;
#(
  parameter int REF_W = REF_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic keypad_stop_key_in,
  input wire logic [REF_W-1:0] analog_one_in,
  input wire logic [REF_W-1:0] precision_ref_in,
  input wire logic [4:0] seq_bits_in,
  input wire logic seq_enable_in,
  input wire logic [REF_W-1:0] active_ref_out,
  input wire logic [3:0] active_source_out,
  input wire logic [4:0] seq_bits_out,
  input wire logic seq_enable_out,
  input wire logic run_command_out,
  input wire logic jog_enable_out,
  input wire logic keypad_mode_out
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Stop key held long enough to clear the pin synchroniser
  sequence stop_held;
    keypad_stop_key_in [*7];
  endsequence

  // Outside keypad mode for two samples, out of reset
  sequence plain_mode;
    !keypad_mode_out && $past(!keypad_mode_out) && $past(!rst_in);
  endsequence

  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus answer not zero-wait okay");
  a_keypad_src: assert property (
    keypad_mode_out |-> active_source_out == SRC_KEYPAD)
    else $error("keypad mode without keypad source");
  a_keypad_seq: assert property (
    keypad_mode_out |-> seq_bits_out == 5'h00 && !seq_enable_out)
    else $error("sequencing bits pass in keypad mode");
  a_keypad_jog: assert property (
    keypad_mode_out |-> !jog_enable_out)
    else $error("jog allowed in keypad mode");
  a_stop_wins: assert property (
    keypad_mode_out throughout stop_held |-> !run_command_out)
    else $error("run stays on with stop key held");
  a_src_legal: assert property (
    active_source_out <= SRC_PRECISION)
    else $error("source code out of range");
  a_prec_path: assert property (
    active_source_out == SRC_PRECISION && $past(!rst_in)
      |-> active_ref_out == $past(precision_ref_in))
    else $error("precision source with wrong value");
  a_an1_path: assert property (
    active_source_out == SRC_ANALOG1 && $past(!rst_in)
      |-> active_ref_out == $past(analog_one_in))
    else $error("analog one source with wrong value");
  a_seq_follow: assert property (
    plain_mode |-> seq_bits_out == $past(seq_bits_in)
      && run_command_out == $past(seq_enable_in && seq_bits_in[0]))
    else $error("sequencing does not follow terminals");
endmodule

bind ssel_ref_selector ssel_checker #(.REF_W(REF_W)) chk_u (.clk_in, .rst_in,
  .hreadyout_out, .hresp_out, .keypad_stop_key_in, .analog_one_in, .precision_ref_in,
  .seq_bits_in, .seq_enable_in, .active_ref_out, .active_source_out, .seq_bits_out,
  .seq_enable_out, .run_command_out, .jog_enable_out, .keypad_mode_out);

// ==== ssel_panel_model.sv ====
/*
  Model of the operator keypad and select terminals.
  Assumes the bench commands it; pins change just after a clock edge.
*/
`timescale 1ns/100ps
module ssel_panel_model (
  input wire logic clk_in,
  input wire logic [3:0] cmd_in, // Stop, run, terminal b, terminal a
  output logic [3:0] pins_out
);
  // Keys and contacts switch once per edge, like a real panel scan
  always_ff @(posedge clk_in) begin
    pins_out <= cmd_in;
  end
endmodule

// ==== tb.sv ====
/*
  Self-checking bench for the reference selector over AHB-Lite.
  Assumes the panel model drives keys and terminals; zero-wait slave.
*/
`timescale 1ns/100ps
module tb;
  import ssel_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic drv_rst = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic hready, hresp;
  logic [3:0] panel_cmd = 4'h0; // Stop, run, b, a
  logic [3:0] pins;
  logic [15:0] an1 = 16'h0a11, an2 = 16'h0a22, prc = 16'h0c33, ref_o;
  logic [4:0] seq_in = 5'h1f, seq_o;
  logic seq_en = 1'b1, jog_req = 1'b1, seq_en_o, run_o, jog_o, kp_o;
  logic [3:0] src_o, prev;
  logic [3:0] scan_exp [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0, 4'h3};
  int n_mismatch = 0;
  int n_tests = 0;
  int cnt;

  // Free-running control clock, 40 ns
  always #20 clk_in = ~clk_in;

  ssel_panel_model panel_u (.clk_in(clk_in), .cmd_in(panel_cmd), .pins_out(pins));

  ssel_ref_selector #(.SCAN_TICK_CYCLES(4)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .drive_reset_in(drv_rst), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .select_terminal_a_in(pins[0]), .select_terminal_b_in(pins[1]),
    .keypad_run_key_in(pins[2]), .keypad_stop_key_in(pins[3]), .analog_one_in(an1),
    .analog_two_in(an2), .precision_ref_in(prc), .seq_bits_in(seq_in),
    .seq_enable_in(seq_en), .jog_request_in(jog_req), .active_ref_out(ref_o),
    .active_source_out(src_o), .seq_bits_out(seq_o), .seq_enable_out(seq_en_o),
    .run_command_out(run_o), .jog_enable_out(jog_o), .keypad_mode_out(kp_o));

  // One single transfer; only the watchdog ends a wait on a dead slave
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask

  // Settle long enough for pins to pass the synchroniser
  task automatic src(input logic [3:0] e, input logic [15:0] r);
    repeat (8) @(posedge clk_in);
    chk("source", {28'h0, e}, {28'h0, src_o});
    chk("reference", {16'h0, r}, {16'h0, ref_o});
  endtask

  task automatic drive_reset();
    @(posedge clk_in);
    drv_rst <= 1'b1;
    @(posedge clk_in);
    drv_rst <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 3000 cycles
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rchk(OFF_MODE, 32'h0);
    rchk(OFF_PSEL, 32'h0);
    rchk(OFF_AUTODIS, 32'h1);
    rchk(8'h40, 32'h0);
    for (int i = 0; i < 8; i++) wr(OFF_PRESET0 + 8'(4 * i), 32'h1001 + i);
    for (int i = 0; i < 8; i++) rchk(OFF_PRESET0 + 8'(4 * i), 32'h1001 + i);
    wr(OFF_MODE, 32'h6);
    rchk(OFF_MODE, 32'h0);
    wr(OFF_PSEL, 32'ha);
    rchk(OFF_PSEL, 32'h0);
    wr(OFF_MODE, 32'h3);
    for (int k = 1; k <= 8; k++) begin
      wr(OFF_PSEL, 32'(k));
      src(4'(k + 1), 16'(32'h1000 + k));
    end
    wr(OFF_MODE, 32'h0);
    for (int k = 2; k <= 8; k++) begin
      wr(OFF_PSEL, 32'(k));
      src(4'(k + 1), 16'(32'h1000 + k));
    end
    // Manual routing kept while auto set-up is off
    wr(OFF_DEST, 32'he);
    rchk(OFF_DEST, 32'he);
    wr(OFF_MODE, 32'h1);
    wr(OFF_PSEL, 32'h0);
    panel_cmd <= 4'h3;
    src(4'h5, 16'h1004);
    panel_cmd <= 4'h0;
    src(SRC_ANALOG1, an1);
    // Auto set-up: routing follows mode only at drive reset
    wr(OFF_AUTODIS, 32'h0);
    wr(OFF_MODE, 32'h0);
    drive_reset();
    rchk(OFF_DEST, 32'h1);
    panel_cmd <= 4'h1;
    src(SRC_ANALOG2, an2);
    wr(OFF_MODE, 32'h2);
    rchk(OFF_DEST, 32'h1);
    drive_reset();
    rchk(OFF_DEST, 32'he);
    wr(OFF_DEST, 32'h0);
    rchk(OFF_DEST, 32'he);
    panel_cmd <= 4'h2;
    src(4'h4, 16'h1003);
    // Keypad mode: keys run, terminals ignored
    panel_cmd <= 4'h0;
    wr(OFF_KEYPAD, 32'h0abc);
    wr(OFF_MODE, 32'h4);
    src(SRC_KEYPAD, 16'h0abc);
    chk("keypad outputs", 32'h1, {24'h0, seq_o, seq_en_o, jog_o, kp_o});
    panel_cmd <= 4'h4;
    repeat (8) @(posedge clk_in);
    chk("run", 32'h1, {31'h0, run_o});
    panel_cmd <= 4'hc;
    repeat (8) @(posedge clk_in);
    chk("run", 32'h0, {31'h0, run_o});
    panel_cmd <= 4'h0;
    wr(OFF_MODE, 32'h5);
    src(SRC_PRECISION, prc);
    // Scan: analog one then presets two to eight, dwell 2 ticks of 4
    seq_in <= 5'h0a;
    wr(OFF_SCAN, 32'h2);
    wr(OFF_MODE, 32'h1);
    wr(OFF_PSEL, 32'h9);
    cnt = 0;
    while (src_o !== 4'h3 && cnt < 200) begin
      @(posedge clk_in);
      cnt++;
    end
    for (int k = 0; k < 8; k++) begin
      prev = src_o;
      cnt = 0;
      do begin @(posedge clk_in); cnt++; end while (src_o === prev && cnt < 50);
      chk("scan dwell", 32'd8, 32'(cnt));
      chk("scan source", {28'h0, scan_exp[k]}, {28'h0, src_o});
    end
    give_verdict();
  end
endmodule
